// ===== rtl/sacc_pkg.sv
/*
  Constants and carrier types for the converter control block.
  Assumes a single 125 MHz clock and a plain register port.
*/
package sacc_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] SACC_OFS_CTRL = 4'h0;   // conv_control_reg
  localparam logic [3:0] SACC_OFS_RES  = 4'h4;   // conv_result_reg, whole word
  localparam logic [3:0] SACC_OFS_DIV  = 4'h8;   // conv_clock_divider_reg
  localparam logic [3:0] SACC_OFS_RESH = 4'hC;   // result_high_part
  localparam logic [3:0] SACC_OFS_RESL = 4'hD;   // result_low_part

  // Control register field positions
  localparam int SACC_CTL_CH_LSB   = 0;    // input_channel_select [3:0]
  localparam int SACC_CTL_START    = 4;    // software_conv_start
  localparam int SACC_CTL_TRIG_EN  = 5;    // timer trigger enable
  localparam int SACC_CTL_DONE     = 7;    // conversion_done_flag
  localparam int SACC_CTL_BUSY     = 8;    // conversion running

  // Sizes and reset values
  localparam int          SACC_RES_W      = 12;     // result width
  localparam int          SACC_CH_NUM     = 14;     // analog inputs
  localparam int          SACC_DIV_W      = 6;      // prescaler width
  localparam int          SACC_CONV_CLKS  = 30;     // converter clocks per conversion
  localparam logic [5:0]  SACC_DIV_RST    = 6'h00;  // prescaler reset value
  localparam logic [3:0]  SACC_CH_RST     = 4'h0;   // channel reset value

  // Converter clock ceiling, in kHz, and the matching least divisor at 125 MHz
  localparam int SACC_CLK_KHZ      = 125000;
  localparam int SACC_ACLK_MAX_KHZ = 4500;
  localparam int SACC_DIV_MIN      = (SACC_CLK_KHZ + SACC_ACLK_MAX_KHZ - 1) / SACC_ACLK_MAX_KHZ;

  // Trigger sources bundled together
  typedef struct packed {
    logic tmr10_match;   // general timer A match
    logic tmr11_match;
    logic tmr12_match;
    logic mot_trig;      // multi_output_timer trigger
  } sacc_trig_type;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sacc_req_type;

endpackage : sacc_pkg

// ===== rtl/sacc_ctrl.sv
/*
  Digital control of a 12-bit successive-approximation converter:
  channel select, prescaler, start logic, bit-by-bit search, result.
  Assumes an analog comparator that settles within one converter clock
  and timer triggers that come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl
  import sacc_pkg::*;
#(
  parameter int RES_W = SACC_RES_W,      // Result width
  parameter int CH_N  = SACC_CH_NUM      // Analog input count
) (
  input  wire logic                clk_i,        // 125 MHz clock
  input  wire logic                rst_n_i,      // Async reset, active low
  input  wire sacc_req_type        req_i,        // Register port request
  output logic [31:0]              rdata_o,      // Read data, cycle after rd
  input  wire sacc_trig_type       trig_i,       // Timer start events
  input  wire logic                cmp_i,        // Comparator: input above DAC level
  output logic [RES_W-1:0]         dac_o,        // Trial code to the converter DAC
  output logic [CH_N-1:0]          mux_sel_o,    // One-hot analog input select
  output logic                     sample_o,     // Sample-and-hold tracking
  output logic                     aclk_o,       // Converter clock level
  output logic                     irq_o         // Conversion-complete interrupt
);

  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_SAMPLE,
    SACC_SEARCH
  } sacc_state_type;

  // Decode of the register port address, used by write and read paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  sacc_state_type     state_q;          // Sequencer state
  logic [3:0]         chan_q;           // input_channel_select
  logic               sw_start_q;       // software_conv_start
  logic               trig_en_q;        // Timer trigger enable
  logic               done_q;           // conversion_done_flag
  logic [5:0]         div_q;            // conv_clock_divider_reg
  logic [5:0]         pre_cnt_q;        // Prescaler counter
  logic               tick_q;           // One-cycle converter clock enable
  logic [4:0]         clk_cnt_q;        // Converter clocks in this conversion
  logic [RES_W-1:0]   sar_q;            // Trial register
  logic [RES_W-1:0]   bit_q;            // One-hot bit under test
  logic [RES_W-1:0]   result_q;         // conv_result_reg
  logic               start_go;         // A conversion starts this cycle
  logic               finish;           // The last converter clock of a conversion
  logic               any_trig;         // Some enabled start source is active
  logic               busy;             // Conversion running

  // Bit phase spans RES_W clocks; the sample window makes up the rest of 30
  localparam logic [4:0] LAST_CLK   = 5'(SACC_CONV_CLKS - 1);
  localparam logic [4:0] SAMPLE_END = 5'(SACC_CONV_CLKS - RES_W - 1);

  assign busy     = (state_q != SACC_IDLE);
  assign any_trig = sw_start_q
                  | (trig_en_q & (trig_i.tmr10_match | trig_i.tmr11_match
                                  | trig_i.tmr12_match | trig_i.mot_trig));
  // Starts are only taken from idle, so a late trigger is dropped
  assign start_go = any_trig & ~busy;
  assign finish   = (state_q == SACC_SEARCH) & tick_q & (clk_cnt_q == LAST_CLK);

  // Timing of one conversion, in converter ticks:
  //   - The prescaler counts free and is never restarted by a start.
  //   - So the first tick after a start lands anywhere from one to
  //     divisor clocks later; software sees a small jitter in latency.
  //   - Restarting the prescaler on each start would remove the jitter,
  //     but would make the converter clock irregular between starts.
  //   - Ticks 1 to 18 form the sample window; the input tracks.
  //   - Ticks 19 to 30 decide the bits, most significant bit first.
  //   - At tick 30 the last bit is decided and the result is latched.
  //   - The interrupt pulse follows one clock after that tick.
  //
  // Comparator timing:
  //   - The trial code leaves on dac_o one clock after sar_q changes.
  //   - The comparator answer arrives a further clock later.
  //   - Hence the divisor must give at least three clocks per tick.
  //   - Any divisor that keeps the converter clock legal does so
  //     with a wide margin, so no extra settling wait is built in.
  //   - With a divisor of one or two the search reads stale answers;
  //     this is a limitation the user must respect.
  //
  // Start sources:
  //   - The software start bit stays set until a conversion begins.
  //   - Timer events are only heard while the trigger enable is set.
  //   - Timer events that arrive while busy are lost, not queued; a queue
  //     would need a depth choice that nothing here calls for.
  //
  // Done flag:
  //   - Set by the finishing tick, cleared by the next start.
  //   - If both fall in one cycle, finishing wins, so a result is
  //     never hidden by a start that races it.
  //   - Reads mask the flag while busy, so software polling the
  //     control register never sees a stale done.
  //
  // Channel select:
  //   - The field holds sixteen codes; only fourteen inputs exist.
  //   - The two spare codes route nothing, and the converter then
  //     searches against an open input.
  //
  // Register reads:
  //   - Read data is registered and stands for one clock only.
  //   - The high part holds result bits eleven to eight in its low
  //     nibble, the low part holds bits seven to zero.
  //   - Writes to the result offsets are ignored.
  //
  // Reset:
  //   - All state returns to idle asynchronously.
  //   - Outputs reset to zero; mux_sel_o selects input 0 from the first clock after release.

  // Prescaler: divisor is register value plus one, so zero still runs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt_q <= 6'h00;
      tick_q    <= 1'b0;
    end else if (pre_cnt_q >= div_q) begin
      pre_cnt_q <= 6'h00;
      tick_q    <= 1'b1;
    end else begin
      pre_cnt_q <= pre_cnt_q + 6'h01;
      tick_q    <= 1'b0;
    end
  end

  // Visible converter clock: high for one clock, the cycle after the enable cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aclk_o <= 1'b0;
    end else begin
      aclk_o <= tick_q;
    end
  end

  // Control register: channel, trigger enable and self-clearing start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_q     <= SACC_CH_RST;
      trig_en_q  <= 1'b0;
      sw_start_q <= 1'b0;
    end else begin
      if (req_i.wr && hit(req_i.addr, SACC_OFS_CTRL)) begin
        chan_q    <= req_i.wdata[SACC_CTL_CH_LSB +: 4];
        trig_en_q <= req_i.wdata[SACC_CTL_TRIG_EN];
      end
      // Begin of conversion wins over a write in the same cycle
      if (start_go) begin
        sw_start_q <= 1'b0;
      end else if (req_i.wr && hit(req_i.addr, SACC_OFS_CTRL)) begin
        sw_start_q <= req_i.wdata[SACC_CTL_START];
      end
    end
  end

  // Prescaler register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= SACC_DIV_RST;
    end else if (req_i.wr && hit(req_i.addr, SACC_OFS_DIV)) begin
      div_q <= req_i.wdata[SACC_DIV_W-1:0];
    end
  end

  // Sequencer: sample window, then one bit per converter clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q   <= SACC_IDLE;
      clk_cnt_q <= 5'h00;
      sar_q     <= '0;
      bit_q     <= '0;
    end else begin
      case (state_q)
        SACC_IDLE: begin
          if (start_go) begin
            state_q   <= SACC_SAMPLE;
            clk_cnt_q <= 5'h00;
          end
        end
        SACC_SAMPLE: begin
          if (tick_q) begin
            clk_cnt_q <= clk_cnt_q + 5'h01;
            if (clk_cnt_q == SAMPLE_END) begin
              state_q <= SACC_SEARCH;
              bit_q   <= {1'b1, {(RES_W-1){1'b0}}};
              sar_q   <= {1'b1, {(RES_W-1){1'b0}}};
            end
          end
        end
        SACC_SEARCH: begin
          if (tick_q) begin
            clk_cnt_q <= clk_cnt_q + 5'h01;
            // Keep the trial bit if input is above, then try the next one
            if (!cmp_i) begin
              sar_q <= (sar_q & ~bit_q) | (bit_q >> 1);
            end else begin
              sar_q <= sar_q | (bit_q >> 1);
            end
            bit_q <= bit_q >> 1;
            if (finish) begin
              state_q <= SACC_IDLE;
            end
          end
        end
        default: begin
          state_q <= SACC_IDLE;
        end
      endcase
    end
  end

  // Result and done flag; a new start clears done, finish sets it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q <= '0;
      done_q   <= 1'b0;
    end else if (finish) begin
      result_q <= cmp_i ? sar_q : (sar_q & ~bit_q);
      done_q   <= 1'b1;
    end else if (start_go) begin
      done_q   <= 1'b0;
    end
  end

  // Interrupt: one-cycle pulse on each completed conversion
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= finish;
    end
  end

  // Analog side outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mux_sel_o <= '0;
      sample_o  <= 1'b0;
      dac_o     <= '0;
    end else begin
      // Channels 14 and 15 select nothing
      mux_sel_o <= (chan_q < 4'(CH_N)) ? (CH_N)'(1) << chan_q : '0;
      sample_o  <= (state_q == SACC_SAMPLE);
      dac_o     <= sar_q;
    end
  end

  // Read port: data stand in the cycle after the strobe only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (req_i.rd) begin
      rdata_o <= 32'h0000_0000;
      if (hit(req_i.addr, SACC_OFS_CTRL)) begin
        rdata_o[SACC_CTL_CH_LSB +: 4] <= chan_q;
        rdata_o[SACC_CTL_START]       <= sw_start_q;
        rdata_o[SACC_CTL_TRIG_EN]     <= trig_en_q;
        rdata_o[SACC_CTL_DONE]        <= done_q & ~busy;
        rdata_o[SACC_CTL_BUSY]        <= busy;
      end else if (hit(req_i.addr, SACC_OFS_RES)) begin
        rdata_o[RES_W-1:0] <= result_q;
      end else if (hit(req_i.addr, SACC_OFS_DIV)) begin
        rdata_o[SACC_DIV_W-1:0] <= div_q;
      end else if (hit(req_i.addr, SACC_OFS_RESH)) begin
        rdata_o[7:0] <= 8'(result_q >> 8);
      end else if (hit(req_i.addr, SACC_OFS_RESL)) begin
        rdata_o[7:0] <= result_q[7:0];
      end
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule : sacc_ctrl
`default_nettype wire

// ===== bench/sacc_ctrl_assertions.sv
/* Port assertions for the converter control block.
   Bound to every sacc_ctrl instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl_assertions
  import sacc_pkg::*;
#(
  parameter int RES_W = SACC_RES_W,  // Result width
  parameter int CH_N  = SACC_CH_NUM  // Input count
) (
  input wire logic            clk_i,
  input wire logic            rst_n_i,
  input wire sacc_req_type    req_i,
  input wire logic [31:0]     rdata_o,
  input wire logic [CH_N-1:0] mux_sel_o,
  input wire logic            sample_o,
  input wire logic            irq_o
);
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Software start written to the control register
  sequence s_start;
    req_i.wr && req_i.addr == SACC_OFS_CTRL && req_i.wdata[SACC_CTL_START];
  endsequence
  // Read strobe at one offset
  sequence s_rd(logic [3:0] ofs);
    req_i.rd && req_i.addr == ofs;
  endsequence
  a_irq_one_cycle: assert property (irq_o |=> !irq_o)
    else $error("interrupt held past one cycle");
  a_done_hidden: assert property (s_rd(SACC_OFS_CTRL) ##0 sample_o |=> !rdata_o[SACC_CTL_DONE])
    else $error("done flag seen while converting");
  a_chan_route: assert property (s_start ##0 req_i.wdata[3:0] < 4'hE
    |-> ##3 mux_sel_o == CH_N'(1) << $past(req_i.wdata[3:0], 3))
    else $error("wrong input routed");
  a_chan_none: assert property (s_start ##0 req_i.wdata[3:0] > 4'hD |-> ##3 mux_sel_o == '0)
    else $error("input routed for missing channel");
  a_mux_onehot: assert property ($onehot0(mux_sel_o))
    else $error("several inputs routed at once");
  a_high_part: assert property (s_rd(SACC_OFS_RESH) |=> rdata_o[31:4] == '0)
    else $error("high part wider than four bits");
  a_low_part: assert property (s_rd(SACC_OFS_RESL) |=> rdata_o[31:8] == '0)
    else $error("low part wider than eight bits");
  a_irq_no_sample: assert property (irq_o |-> !sample_o)
    else $error("interrupt during sample window");
endmodule : sacc_ctrl_assertions
bind sacc_ctrl sacc_ctrl_assertions #(.RES_W(RES_W), .CH_N(CH_N)) u_sacc_chk (
  .clk_i, .rst_n_i, .req_i, .rdata_o, .mux_sel_o, .sample_o, .irq_o);
`default_nettype wire

// ===== bench/sacc_analog_model.sv
/* Behavioural analog core: input multiplexer, DAC and comparator.
   Assumes a one-hot channel select and a 12-bit trial code. */
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model (
  input  wire logic        clk_i,      // Same clock as the control
  input  wire logic [13:0] mux_sel_i,  // One-hot input select
  input  wire logic [11:0] dac_i,      // Trial code
  output var  logic        cmp_o       // High when input >= trial
);
  logic [11:0] lvl;  // Level of the routed input, 0 if none
  // Each input holds a fixed, distinct level
  always_comb begin
    lvl = 12'h000;
    for (int c = 0; c < 14; c++) begin
      if (mux_sel_i[c]) begin
        lvl = 12'h0a5 + 12'(c) * 12'h111;
      end
    end
  end
  // Settles one clock late, still well inside a converter tick
  always_ff @(posedge clk_i) begin
    cmp_o <= (lvl >= dac_i);
  end
endmodule : sacc_analog_model
`default_nettype wire

// ===== bench/test_sacc_ctrl.sv
/* Self-checking bench for the converter control block.
   Assumes the analog model and the bound checker beside it. */
`timescale 1ns/1ps
`default_nettype none
module test_sacc_ctrl
  import sacc_pkg::*;
;
  logic           clk_i   = 1'b0;  // 125 MHz clock
  logic           rst_n_i = 1'b0;  // Reset, active low
  sacc_req_type   req     = '0;    // Register port request
  sacc_trig_type  trig    = '0;    // Timer events
  logic [31:0]    rdata;
  logic [11:0]    dac;
  logic [13:0]    mux;
  logic           cmp, smp, aclk, irq;
  int             err_total = 0, num_checks = 0, cyc = 0, t0;
  int             chs[4] = '{0, 5, 13, 14};  // Edge and middle channels, 14 has no input
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  sacc_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
    .trig_i(trig), .cmp_i(cmp), .dac_o(dac), .mux_sel_o(mux), .sample_o(smp),
    .aclk_o(aclk), .irq_o(irq));
  sacc_analog_model u_ana (.clk_i(clk_i), .mux_sel_i(mux), .dac_i(dac), .cmp_o(cmp));
  // Level the model gives for a channel
  function automatic logic [31:0] lvl(input int ch);
    return (ch < 14) ? 32'(12'h0a5 + 12'(ch) * 12'h111) : 32'h0000_0000;
  endfunction : lvl
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i) req.wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i) req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i) req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic pulse(input logic [3:0] v);
    @(posedge clk_i) trig <= sacc_trig_type'(v);
    @(posedge clk_i) trig <= '0;
  endtask : pulse
  // Bounded wait for the interrupt, then check 30 ticks of 28 clocks.
  // The prescaler runs free, so the first tick lands 1 to 28 clocks after
  // the start; the window allows for that phase and for how t0 is taken.
  task automatic conv_wait();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n >= 2000) begin
      chk(32'h0000_0000, 32'h0000_0001);
      summarize();
    end else begin
      chk(32'((cyc - t0) inside {[814:842]}), 32'h0000_0001);
    end
  endtask : conv_wait
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(SACC_OFS_CTRL, 32'h0000_0000);
    rd(SACC_OFS_DIV, 32'h0000_0000);
    wr(SACC_OFS_RES, 32'h0000_0fff);
    rd(SACC_OFS_RESL, 32'h0000_0000);
    rd(4'h3, 32'h0000_0000);
    wr(SACC_OFS_DIV, 32'h0000_001b);
    rd(SACC_OFS_DIV, 32'h0000_001b);
    $display("test registers done");
    foreach (chs[i]) begin
      wr(SACC_OFS_CTRL, 32'h0000_0030 | chs[i]);
      t0 = cyc;
      repeat (2) @(posedge clk_i);
      rd(SACC_OFS_CTRL, 32'h0000_0120 | chs[i]);
      pulse(4'hf);
      conv_wait();
      rd(SACC_OFS_RES, lvl(chs[i]));
      rd(SACC_OFS_RESH, lvl(chs[i]) >> 8);
      rd(SACC_OFS_RESL, lvl(chs[i]) & 32'h0000_00ff);
      rd(SACC_OFS_CTRL, 32'h0000_00a0 | chs[i]);
    end
    $display("test software start done");
    wr(SACC_OFS_CTRL, 32'h0000_0005);
    pulse(4'hf);
    repeat (40) @(posedge clk_i);
    rd(SACC_OFS_CTRL, 32'h0000_0085);
    wr(SACC_OFS_CTRL, 32'h0000_0025);
    for (int i = 0; i < 4; i++) begin
      pulse(4'(1 << i));
      t0 = cyc;
      conv_wait();
      rd(SACC_OFS_RES, lvl(5));
    end
    $display("test timer start done");
    summarize();
  end
endmodule : test_sacc_ctrl
`default_nettype wire
